// file: design/i2rs_pkg.sv
/*
 * Shared constants and types of the two-wire register slave port.
 * Assumes a 40 MHz system clock and a slower, unrelated register clock.
 */
`default_nettype none

package i2rs_pkg;

	// ==========================================================
	// Bus address
	// ==========================================================
	localparam logic [6:0] OWN_ADDR = 7'h2D;
	localparam logic [7:0] ADDR_WR_BYTE = {OWN_ADDR, 1'b0};
	localparam logic [7:0] ADDR_RD_BYTE = {OWN_ADDR, 1'b1};

	// ==========================================================
	// Byte framing and counts
	// ==========================================================
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] BIT_CNT_RESET = 4'h0;
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	localparam logic [1:0] STRAP_CNT_RESET = 2'h0;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam int FIFO_DEPTH = 16;

	// ==========================================================
	// Request word passed to the register clock domain
	// ==========================================================
	typedef struct packed {
		logic rd;
		logic [7:0] addr;
		logic [7:0] data;
	} i2rs_req_t;

	localparam int REQ_W = $bits(i2rs_req_t);
	localparam i2rs_req_t REQ_RESET = '{rd: 1'b0, addr: 8'h00, data: 8'h00};

	// ==========================================================
	// Serial engine states
	// ==========================================================
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_ADDR = 4'b0001,
		ST_ADDR_ACK = 4'b0010,
		ST_REG = 4'b0011,
		ST_REG_ACK = 4'b0100,
		ST_WDATA = 4'b0101,
		ST_WDATA_ACK = 4'b0110,
		ST_RDATA = 4'b0111,
		ST_RACK = 4'b1000,
		ST_IGNORE = 4'b1001
	} i2rs_state_t;

endpackage

`default_nettype wire

// file: design/i2rs_fifo_if.sv
/*
 * Valid/ready carrier between the serial engine and its request buffer.
 * Assumes all signals live in the system clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

interface i2rs_fifo_if #(parameter int W = 8);
	logic push_valid;
	logic push_ready;
	logic [W-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [W-1:0] pop_data;

	modport src (output push_valid, output push_data, input push_ready);
	modport buffer (input push_valid, input push_data, input pop_ready,
		output push_ready, output pop_valid, output pop_data);
	modport sink (input pop_valid, input pop_data, output pop_ready);
endinterface

`default_nettype wire

// file: design/i2rs_fifo.sv
/*
 * Synchronous request FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two and a single clock for both sides.
 */
`timescale 1ns/1ps
`default_nettype none

module i2rs_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	i2rs_fifo_if.buffer f
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic do_push;
	logic do_pop;

	// Extra pointer bit tells full from empty
	function automatic logic [AW:0] bump(input logic [AW:0] p);
		return p + {{AW{1'b0}}, 1'b1};
	endfunction

	assign f.push_ready = ~((wr_ptr[AW] != rd_ptr[AW]) &&
		(wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
	assign f.pop_valid = (wr_ptr != rd_ptr);
	assign f.pop_data = mem[rd_ptr[AW-1:0]];
	assign do_push = f.push_valid & f.push_ready;
	assign do_pop = f.pop_valid & f.pop_ready;

	// ==========================================================
	// Storage
	// ==========================================================
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wr_ptr[AW-1:0]] <= f.push_data;
		end
	end

	// ==========================================================
	// Pointers
	// ==========================================================
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= bump(wr_ptr);
			end
			if (do_pop) begin
				rd_ptr <= bump(rd_ptr);
			end
		end
	end
endmodule

`default_nettype wire

// file: design/i2rs_slave_port.sv
/*
 * Two-wire register slave port: pin synchronisers, start/stop detection,
 * serial byte engine, request FIFO and a toggle handshake into the
 * register clock domain where the register file is strobed.
 * Assumes open-drain pins resolved outside, a register file that answers
 * reg_rd_data combinationally from reg_addr, and an if_sel strap.
 */
// Notes on behaviour
// - The port is only ever a target: it has no clock output and never makes start or stop.
// - Data are sampled on the rising serial clock and changed only after it falls.
// - A data edge while the clock is high mid-transfer drops the transfer and any partial byte.
// - Bytes are eight bits, MSB first, one per clock pulse, each followed by an acknowledge slot.
// - Falling data with clock high is start, rising data with clock high is stop, seen anytime.
// - A repeated start restarts address decoding so a read can follow the register address.
// - The receiver pulls data low through the whole ninth clock pulse to acknowledge.
// - The transmitter releases data in the ninth clock, so the port lets go after read data.
// - The own 7-bit address is 2Dh, seen as 5Ah for write and 5Bh for read.
// - Seven address bits follow a start, the eighth is direction, 1 read and 0 write.
// - Only a matching address is acknowledged; otherwise data stays released until the next start or stop.
// - A write is address, register address, data byte stored in the register, then stop.
// - A read is address, register address, repeated start, read address, data, not-ack, stop.
// - Two-wire mode is taken from the select strap after reset and never changes later.
`timescale 1ns/1ps
`default_nettype none

module i2rs_slave_port (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_reg,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic if_sel,
	output logic i2c_mode,
	output logic bus_busy,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wr_data,
	input wire logic [7:0] reg_rd_data
);
	import i2rs_pkg::*;

	logic scl_m;
	logic scl_s;
	logic scl_d;
	logic sda_m;
	logic sda_s;
	logic sda_d;
	logic if_m;
	logic if_s;
	logic [1:0] strap_cnt;
	logic strap_done;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic byte_end;
	logic addr_hit;
	i2rs_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] tx_byte;
	logic [7:0] reg_ptr;
	logic [7:0] rd_data;
	logic rw;
	logic master_nack;
	logic push_valid;
	i2rs_req_t push_data;
	logic hs_busy;
	logic req_tgl;
	logic ack_m;
	logic ack_s;
	logic ack_d;
	i2rs_req_t hold;
	logic req_m;
	logic req_s;
	logic req_d;
	logic pend;
	logic ack_tgl;
	logic [7:0] resp;

	i2rs_fifo_if #(.W(REQ_W)) fifo_bus ();

	function automatic i2rs_req_t pack_req(input logic rd,
		input logic [7:0] addr, input logic [7:0] data);
		i2rs_req_t r;
		r.rd = rd;
		r.addr = addr;
		r.data = data;
		return r;
	endfunction

	function automatic logic [7:0] next_byte(input logic [7:0] b);
		return b + 8'h01;
	endfunction

	// ==========================================================
	// Pin side
	// ==========================================================
	// Open drain: only ever pulls low, and there is no clock driver
	assign sda_o = 1'b0;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
			if_m <= 1'b1;
			if_s <= 1'b1;
		end else begin
			scl_m <= scl_i;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= sda_i;
			sda_s <= sda_m;
			sda_d <= sda_s;
			if_m <= if_sel;
			if_s <= if_m;
		end
	end

	// Edge and condition decode on the settled copies only
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;
	assign byte_end = scl_fall && (bit_cnt == BITS_PER_BYTE);
	assign addr_hit = (shreg == ADDR_WR_BYTE) || (shreg == ADDR_RD_BYTE);

	// ==========================================================
	// Interface strap
	// ==========================================================
	// Wait for the synchroniser to fill, then freeze the choice
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			strap_cnt <= STRAP_CNT_RESET;
			strap_done <= 1'b0;
			i2c_mode <= 1'b0;
		end else if (!strap_done) begin
			if (strap_cnt == STRAP_WAIT) begin
				i2c_mode <= ~if_s;
				strap_done <= 1'b1;
			end else begin
				strap_cnt <= strap_cnt + 2'h1;
			end
		end
	end

	// ==========================================================
	// Bus occupancy
	// ==========================================================
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bus_busy <= 1'b0;
		end else if (!i2c_mode) begin
			bus_busy <= 1'b0;
		end else if (start_cond) begin
			bus_busy <= 1'b1;
		end else if (stop_cond) begin
			bus_busy <= 1'b0;
		end
	end

	// ==========================================================
	// Serial engine
	// ==========================================================
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			bit_cnt <= BIT_CNT_RESET;
			shreg <= BYTE_RESET;
			tx_byte <= BYTE_RESET;
			reg_ptr <= BYTE_RESET;
			rw <= 1'b0;
			master_nack <= 1'b1;
			sda_oe <= 1'b0;
			push_valid <= 1'b0;
			push_data <= REQ_RESET;
		end else begin
			push_valid <= 1'b0;
			if (!i2c_mode) begin
				state <= ST_IDLE;
				sda_oe <= 1'b0;
			end else if (start_cond) begin
				// Partial byte is thrown away, decoding starts over
				state <= ST_ADDR;
				bit_cnt <= BIT_CNT_RESET;
				sda_oe <= 1'b0;
			end else if (stop_cond) begin
				state <= ST_IDLE;
				bit_cnt <= BIT_CNT_RESET;
				sda_oe <= 1'b0;
			end else begin
				case (state)
				ST_ADDR, ST_REG, ST_WDATA: begin
					if (scl_rise && bit_cnt != BITS_PER_BYTE) begin
						shreg <= {shreg[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (byte_end) begin
						bit_cnt <= BIT_CNT_RESET;
						case (state)
						ST_ADDR: begin
							if (addr_hit) begin
								sda_oe <= 1'b1;
								rw <= shreg[0];
								state <= ST_ADDR_ACK;
								if (shreg[0]) begin
									// Fetch starts now so data is back
									// before the ack pulse ends
									push_valid <= fifo_bus.push_ready;
									push_data <= pack_req(1'b1, reg_ptr,
										BYTE_RESET);
								end
							end else begin
								state <= ST_IGNORE;
							end
						end
						ST_REG: begin
							reg_ptr <= shreg;
							sda_oe <= 1'b1;
							state <= ST_REG_ACK;
						end
						default: begin
							// A full buffer answers with no-acknowledge
							if (fifo_bus.push_ready) begin
								push_valid <= 1'b1;
								push_data <= pack_req(1'b0, reg_ptr, shreg);
								reg_ptr <= next_byte(reg_ptr);
								sda_oe <= 1'b1;
							end
							state <= ST_WDATA_ACK;
						end
						endcase
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						if (rw) begin
							tx_byte <= rd_data;
							sda_oe <= ~rd_data[7];
							bit_cnt <= BIT_CNT_RESET;
							state <= ST_RDATA;
						end else begin
							sda_oe <= 1'b0;
							state <= ST_REG;
						end
					end
				end
				ST_REG_ACK, ST_WDATA_ACK: begin
					if (scl_fall) begin
						sda_oe <= 1'b0;
						state <= ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (scl_rise) begin
						bit_cnt <= bit_cnt + 4'h1;
					end else if (byte_end) begin
						sda_oe <= 1'b0;
						bit_cnt <= BIT_CNT_RESET;
						reg_ptr <= next_byte(reg_ptr);
						push_valid <= fifo_bus.push_ready;
						push_data <= pack_req(1'b1, next_byte(reg_ptr),
							BYTE_RESET);
						state <= ST_RACK;
					end else if (scl_fall) begin
						tx_byte <= {tx_byte[6:0], 1'b0};
						sda_oe <= ~tx_byte[6];
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						master_nack <= sda_s;
					end else if (scl_fall) begin
						if (!master_nack) begin
							tx_byte <= rd_data;
							sda_oe <= ~rd_data[7];
							state <= ST_RDATA;
						end else begin
							sda_oe <= 1'b0;
							state <= ST_IGNORE;
						end
					end
				end
				ST_IGNORE: begin
					sda_oe <= 1'b0;
				end
				default: begin
					sda_oe <= 1'b0;
					state <= ST_IDLE;
				end
				endcase
			end
		end
	end

	// ==========================================================
	// Request buffer
	// ==========================================================
	assign fifo_bus.push_valid = push_valid;
	assign fifo_bus.push_data = push_data;
	assign fifo_bus.pop_ready = ~hs_busy;

	i2rs_fifo #(.W(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk_sys),
		.rst(rst),
		.f(fifo_bus.buffer)
	);

	// ==========================================================
	// Handshake, system side
	// ==========================================================
	// hold stays frozen while busy, so the far side reads it safely
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ack_m <= 1'b0;
			ack_s <= 1'b0;
			ack_d <= 1'b0;
			hs_busy <= 1'b0;
			req_tgl <= 1'b0;
			hold <= REQ_RESET;
			rd_data <= BYTE_RESET;
		end else begin
			ack_m <= ack_tgl;
			ack_s <= ack_m;
			ack_d <= ack_s;
			if (fifo_bus.pop_valid && !hs_busy) begin
				hold <= fifo_bus.pop_data;
				req_tgl <= ~req_tgl;
				hs_busy <= 1'b1;
			end else if (ack_s != ack_d) begin
				hs_busy <= 1'b0;
				if (hold.rd) begin
					rd_data <= resp;
				end
			end
		end
	end

	// ==========================================================
	// Handshake, register side
	// ==========================================================
	always_ff @(posedge clk_reg or posedge rst) begin
		if (rst) begin
			req_m <= 1'b0;
			req_s <= 1'b0;
			req_d <= 1'b0;
			pend <= 1'b0;
			ack_tgl <= 1'b0;
			resp <= BYTE_RESET;
			reg_wr_en <= 1'b0;
			reg_rd_en <= 1'b0;
			reg_addr <= BYTE_RESET;
			reg_wr_data <= BYTE_RESET;
		end else begin
			req_m <= req_tgl;
			req_s <= req_m;
			req_d <= req_s;
			reg_wr_en <= 1'b0;
			reg_rd_en <= 1'b0;
			if (req_s != req_d) begin
				reg_addr <= hold.addr;
				reg_wr_data <= hold.data;
				reg_rd_en <= hold.rd;
				reg_wr_en <= ~hold.rd;
				pend <= 1'b1;
			end else if (pend) begin
				pend <= 1'b0;
				if (reg_rd_en) begin
					resp <= reg_rd_data;
				end
				ack_tgl <= ~ack_tgl;
			end
		end
	end
endmodule

`default_nettype wire

// file: verification/i2rs_master_model.sv
/*
 * Bus master model driving the serial clock and data pins of the port.
 * Assumes a pull-up on the data line and a 40 MHz reference clock.
 */
`timescale 1ns/1ps
`default_nettype none

module i2rs_master_model (
	input wire logic clk,
	input wire logic sda_oe,
	output logic scl,
	output wire logic sda_w
);
	// ==========================================================
	// Wired data line
	// ==========================================================
	logic sda_m = 1'b1;
	// Pull-up wins when nobody pulls low
	assign sda_w = sda_m & ~sda_oe;
	initial scl = 1'b1;

	// Phase of 34 cycles; a bit takes three phases, near 400 kHz
	task automatic hp;
		repeat (34) @(posedge clk);
	endtask

	task automatic m_start;
		sda_m <= 1'b1;
		hp();
		scl <= 1'b1;
		hp();
		sda_m <= 1'b0;
		hp();
		scl <= 1'b0;
		hp();
	endtask

	task automatic m_stop;
		sda_m <= 1'b0;
		hp();
		scl <= 1'b1;
		hp();
		sda_m <= 1'b1;
		hp();
	endtask

	// Data changes only while the clock is low
	task automatic m_bit(input logic b, output logic r);
		sda_m <= b;
		hp();
		scl <= 1'b1;
		hp();
		r = sda_w;
		scl <= 1'b0;
		hp();
	endtask

	task automatic m_byte(input logic [7:0] tx, input logic ackbit,
		output logic [7:0] rx, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			m_bit(tx[i], r);
			rx[i] = r;
		end
		m_bit(ackbit, r);
		ack = ~r;
	endtask
endmodule

`default_nettype wire

// file: verification/i2rs_slave_port_sva.sv
/*
 * Concurrent checks on the ports of the two-wire register slave port.
 * Assumes the bench keeps serial clock phases of many system cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module i2rs_slave_port_sva (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_reg,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic if_sel,
	input wire logic i2c_mode,
	input wire logic bus_busy,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	input wire logic [7:0] reg_rd_data
);
	// ==========================================================
	// Serial side
	// ==========================================================
	AST_OPEN_DRAIN: assert property (
		@(posedge clk_sys) disable iff (rst)
		sda_o == 1'b0)
		else $error("data pin driven high");
	AST_SDA_LOW_PHASE: assert property (
		@(posedge clk_sys) disable iff (rst)
		$changed(sda_oe) |-> !scl_i)
		else $error("data moved with clock high");
	AST_ACK_HIGH: assert property (
		@(posedge clk_sys) disable iff (rst)
		$rose(scl_i) && sda_oe |-> sda_oe [*4])
		else $error("pull dropped");
	AST_BUSY_START: assert property (
		@(posedge clk_sys) disable iff (rst)
		i2c_mode && scl_i && $fell(sda_i) |-> ##[1:6] bus_busy)
		else $error("start not seen");
	AST_BUSY_STOP: assert property (
		@(posedge clk_sys) disable iff (rst)
		scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:6] !bus_busy)
		else $error("stop not seen");
	AST_IDLE_RELEASED: assert property (
		@(posedge clk_sys) disable iff (rst)
		!bus_busy |-> !sda_oe)
		else $error("driving while idle");
	AST_MODE_HOLD: assert property (
		@(posedge clk_sys) disable iff (rst)
		i2c_mode |=> i2c_mode)
		else $error("mode changed");
	AST_MODE_GATE: assert property (
		@(posedge clk_sys) disable iff (rst)
		!i2c_mode |-> !sda_oe && !bus_busy)
		else $error("active off mode");
	// ==========================================================
	// Register side
	// ==========================================================
	AST_WR_PULSE: assert property (
		@(posedge clk_reg) disable iff (rst)
		reg_wr_en |=> !reg_wr_en)
		else $error("write strobe too long");
	AST_RD_PULSE: assert property (
		@(posedge clk_reg) disable iff (rst)
		reg_rd_en |=> !reg_rd_en && !reg_wr_en)
		else $error("bad read strobe");
endmodule

bind i2rs_slave_port i2rs_slave_port_sva u_sva (.clk_sys(clk_sys),
	.rst(rst), .clk_reg(clk_reg), .scl_i(scl_i), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe(sda_oe), .if_sel(if_sel), .i2c_mode(i2c_mode),
	.bus_busy(bus_busy), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
	.reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
	.reg_rd_data(reg_rd_data));

`default_nettype wire

// file: verification/tb_i2rs_slave_port.sv
/*
 * Self-checking bench for the two-wire register slave port.
 * Assumes the master model and a simple register file on clk_reg.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_i2rs_slave_port;
	import i2rs_pkg::*;
	logic clk_sys = 1'b0;
	logic clk_reg = 1'b0;
	logic rst = 1'b1;
	logic if_sel = 1'b0;
	logic scl, sda_w, sda_o, sda_oe, i2c_mode, bus_busy;
	logic reg_wr_en, reg_rd_en;
	logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
	logic [7:0] mem [256] = '{default: 8'h00};
	int err_total = 0;
	int n_compared = 0;

	// ==========================================================
	// Clocks, register file, instances
	// ==========================================================
	initial forever #12.5 clk_sys = ~clk_sys;
	initial begin
		#7;
		forever #32 clk_reg = ~clk_reg;
	end
	assign reg_rd_data = mem[reg_addr];
	always @(posedge clk_reg) begin
		if (reg_wr_en) mem[reg_addr] <= reg_wr_data;
	end

	i2rs_slave_port DUT (.clk_sys(clk_sys), .rst(rst), .clk_reg(clk_reg),
		.scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
		.if_sel(if_sel), .i2c_mode(i2c_mode), .bus_busy(bus_busy),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data));
	i2rs_master_model m (.clk(clk_sys), .sda_oe(sda_oe), .scl(scl),
		.sda_w(sda_w));

	// ==========================================================
	// Reporting
	// ==========================================================
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	// ==========================================================
	task automatic s_mode;
		chk({7'h00, i2c_mode}, 8'h01, "mode after strap");
		if_sel <= 1'b1;
		repeat (20) @(posedge clk_sys);
		chk({7'h00, i2c_mode}, 8'h01, "mode frozen");
		if_sel <= 1'b0;
	endtask

	task automatic s_write(input logic [7:0] ra, input logic [7:0] d);
		logic [7:0] rx;
		logic a;
		m.m_start();
		chk({7'h00, bus_busy}, 8'h01, "busy");
		m.m_byte(ADDR_WR_BYTE, 1'b1, rx, a);
		chk({7'h00, a}, 8'h01, "addr ack");
		m.m_byte(ra, 1'b1, rx, a);
		chk({7'h00, a}, 8'h01, "reg ack");
		m.m_byte(d, 1'b1, rx, a);
		chk({7'h00, a}, 8'h01, "data ack");
		m.m_stop();
		for (int k = 0; k < 200 && mem[ra] !== d; k++) @(posedge clk_sys);
		chk(mem[ra], d, "stored");
		if (mem[ra] !== d) tally_and_finish();
	endtask

	task automatic s_read(input logic [7:0] ra, input logic [7:0] exp);
		logic [7:0] rx;
		logic a;
		m.m_start();
		m.m_byte(ADDR_WR_BYTE, 1'b1, rx, a);
		m.m_byte(ra, 1'b1, rx, a);
		m.m_start();
		m.m_byte(ADDR_RD_BYTE, 1'b1, rx, a);
		chk({7'h00, a}, 8'h01, "read addr ack");
		m.m_byte(8'hFF, 1'b1, rx, a);
		chk(rx, exp, "read data");
		chk({7'h00, sda_oe}, 8'h00, "released after nack");
		m.m_stop();
		repeat (10) @(posedge clk_sys);
		chk({7'h00, bus_busy}, 8'h00, "idle after stop");
	endtask

	task automatic s_nomatch;
		logic [7:0] rx;
		logic a;
		m.m_start();
		m.m_byte(8'h58, 1'b1, rx, a);
		chk({7'h00, a}, 8'h00, "foreign addr");
		m.m_byte(8'h10, 1'b1, rx, a);
		chk({7'h00, a}, 8'h00, "stays released");
		m.m_stop();
	endtask

	// Stop in mid-byte: the partial data byte must not reach a register.
	// Pulses after the stop would finish the byte if it were still kept.
	task automatic s_abort;
		logic [7:0] rx;
		logic a;
		logic r;
		m.m_start();
		m.m_byte(ADDR_WR_BYTE, 1'b1, rx, a);
		m.m_byte(8'h20, 1'b1, rx, a);
		for (int i = 7; i >= 4; i--) m.m_bit(1'b1, r);
		m.m_stop();
		for (int i = 0; i < 4; i++) m.m_bit(1'b1, r);
		repeat (100) @(posedge clk_sys);
		chk(mem[8'h20], 8'h00, "aborted byte");
	endtask

	// Two data bytes land at consecutive registers and come back in one
	// read, the first byte acknowledged by the master, the last not
	task automatic s_burst;
		logic [7:0] rx;
		logic a;
		m.m_start();
		m.m_byte(ADDR_WR_BYTE, 1'b1, rx, a);
		m.m_byte(8'h30, 1'b1, rx, a);
		m.m_byte(8'h69, 1'b1, rx, a);
		m.m_byte(8'hC3, 1'b1, rx, a);
		chk({7'h00, a}, 8'h01, "second data ack");
		m.m_stop();
		m.m_start();
		m.m_byte(ADDR_WR_BYTE, 1'b1, rx, a);
		m.m_byte(8'h30, 1'b1, rx, a);
		m.m_start();
		m.m_byte(ADDR_RD_BYTE, 1'b1, rx, a);
		m.m_byte(8'hFF, 1'b0, rx, a);
		chk(rx, 8'h69, "burst byte one");
		m.m_byte(8'hFF, 1'b1, rx, a);
		chk(rx, 8'hC3, "burst byte two");
		chk({7'h00, sda_oe}, 8'h00, "burst released");
		m.m_stop();
	endtask

	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (10) @(posedge clk_sys);
		s_mode();
		s_write(8'h10, 8'hA5);
		s_read(8'h10, 8'hA5);
		s_nomatch();
		s_abort();
		s_write(8'h20, 8'h3C);
		s_read(8'h20, 8'h3C);
		s_read(8'h10, 8'hA5);
		s_burst();
		tally_and_finish();
	end

	initial begin
		repeat (90000) @(posedge clk_sys);
		err_total++;
		$display("ERROR %0t run timed out", $time);
		tally_and_finish();
	end
endmodule

`default_nettype wire
